/* File: bench/srhi_host_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module srhi_host_checker
    import srhi_pkg::*;
#(
    parameter int REF_FULL = 50,
    parameter int PWRUP = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Processor side
    input wire logic addrStrobe,
    input wire logic readyIn,
    input wire logic memSpaceIn,
    input wire logic [15:0] addrIn,
    input wire logic writeReq_n,
    input wire logic memory_store_command_n,
    input wire logic useStoreCmd,
    input wire logic mcuMode,
    input wire logic gating_port_bit,
    input wire logic readReq_n,
    // RAM side
    input wire logic cpuClk,
    input wire logic chipSel_n,
    input wire logic store_n,
    input wire logic outEn_n,
    input wire logic refresh_strobe_n,
    input wire logic falseCycle
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] upCnt_ff;
    logic [1:0] falls_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upCnt_ff <= '0;
            falls_ff <= '0;
        end else begin
            if (upCnt_ff < 16'(PWRUP)) upCnt_ff <= upCnt_ff + 16'h0001;
            if ($rose(addrStrobe)) falls_ff <= 2'h0;
            else if ($fell(chipSel_n) && falls_ff != 2'h3) falls_ff <= falls_ff + 2'h1;
        end
    end
    sequence highEight;
        cpuClk [*4] ##1 cpuClk [*4];
    endsequence
    a_reset_sel_off: assert property (disable iff (1'b0) !rst_n |-> chipSel_n && store_n)
        else $error("select or store active in reset");
    a_pwrup_hold: assert property (upCnt_ff < 16'(PWRUP - 2) |-> chipSel_n && !refresh_strobe_n)
        else $error("power-up hold broken");
    a_one_fall: assert property (falls_ff < 2'h2)
        else $error("two select falls in one strobe cycle");
    a_sel_after_strobe: assert property ($fell(chipSel_n) |-> !addrStrobe && !$past(addrStrobe, 2) && (mcuMode || memSpaceIn))
        else $error("select fell without a memory strobe fall");
    a_mcu_gate: assert property ($fell(chipSel_n) && mcuMode |-> addrIn < LOW_SPACE_TOP && !$past(gating_port_bit, 2))
        else $error("select in gated mode without port bit low");
    a_precharge_norm: assert property ($rose(chipSel_n) |-> chipSel_n [*2])
        else $error("select high time short");
    a_precharge_false: assert property ($rose(chipSel_n) && falseCycle |-> chipSel_n [*3])
        else $error("select high time short after false cycle");
    a_wait_hold: assert property ((!readyIn [*4]) ##0 !chipSel_n |=> !chipSel_n)
        else $error("select released while not ready");
    a_store_sync: assert property ($fell(store_n) |-> !chipSel_n && (useStoreCmd ? !$past(memory_store_command_n) : !$past(writeReq_n, 2)))
        else $error("store pulse without its cause");
    a_clk_divide: assert property (refresh_strobe_n && $past(refresh_strobe_n, 3) |-> cpuClk != $past(cpuClk))
        else $error("processor clock not toggling");
    a_stretch_high: assert property ($fell(refresh_strobe_n) |-> ##1 highEight)
        else $error("processor clock not held high for refresh");
    a_stretch_ends: assert property ($fell(refresh_strobe_n) |-> ##[10:14] refresh_strobe_n)
        else $error("refresh strobe not ended");
    a_refresh_at_strobe: assert property ($fell(refresh_strobe_n) |-> addrStrobe && $past(addrStrobe, 2))
        else $error("refresh strobe outside strobe high");
endmodule
bind srhi_host srhi_host_checker #(.REF_FULL(REF_FULL), .PWRUP(PWRUP)) srhi_host_checker_inst (
    .clk(clk), .rst_n(rst_n), .addrStrobe(addrStrobe), .readyIn(readyIn),
    .memSpaceIn(memSpaceIn), .addrIn(addrIn), .writeReq_n(writeReq_n),
    .memory_store_command_n(memory_store_command_n), .useStoreCmd(useStoreCmd),
    .mcuMode(mcuMode), .gating_port_bit(gating_port_bit), .readReq_n(readReq_n),
    .cpuClk(cpuClk), .chipSel_n(chipSel_n), .store_n(store_n), .outEn_n(outEn_n),
    .refresh_strobe_n(refresh_strobe_n), .falseCycle(falseCycle));
`default_nettype wire

/* File: bench/srhi_ram_model.sv */
`timescale 1ns/100ps
`default_nettype none
module srhi_ram_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // RAM pins
    input wire logic chipSel_n,
    input wire logic store_n,
    input wire logic refresh_strobe_n,
    output logic readyIn,
    // Commanded internal busy span
    input wire logic [3:0] busyLen,
    input wire logic busyGo,
    // Observed events
    output logic [7:0] selCnt,
    output logic [7:0] storeCnt,
    output logic [7:0] refCnt
);
    logic selPrev, stPrev, refPrev;
    logic [3:0] busyLeft;
    // Busy is commanded ahead of select, since the host sees ready two flops late
    assign readyIn = (busyLeft == 4'h0);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {selPrev, stPrev, refPrev} <= 3'h6;
            {selCnt, storeCnt, refCnt} <= '0;
            busyLeft <= 4'h0;
        end else begin
            {selPrev, stPrev, refPrev} <= {chipSel_n, store_n, refresh_strobe_n};
            // Address taken on the fall; any select length accepted
            if (selPrev && !chipSel_n) selCnt <= selCnt + 8'h01;
            if (stPrev && !store_n) storeCnt <= storeCnt + 8'h01;
            if (refPrev && !refresh_strobe_n) refCnt <= refCnt + 8'h01;
            if (busyGo) busyLeft <= busyLen;
            else if (busyLeft != 4'h0) busyLeft <= busyLeft - 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import srhi_pkg::*;
    localparam int REF_FULL = 50;
    localparam int PWRUP = 20;
    logic clk, rst_n, addrStrobe, readyIn, memSpaceIn, writeReq_n, memory_store_command_n;
    logic useStoreCmd, mcuMode, gating_port_bit, readReq_n, cpuClk, chipSel_n, store_n;
    logic outEn_n, refresh_strobe_n, falseCycle, busyGo;
    logic [15:0] addrIn;
    logic [3:0] busyLen;
    logic [7:0] selCnt, storeCnt, refCnt;
    int n_fail = 0;
    int n_checks = 0;
    srhi_host #(.REF_FULL(REF_FULL), .PWRUP(PWRUP)) srhi_host_inst (
        .clk(clk), .rst_n(rst_n), .addrStrobe(addrStrobe), .readyIn(readyIn),
        .memSpaceIn(memSpaceIn), .addrIn(addrIn), .writeReq_n(writeReq_n),
        .memory_store_command_n(memory_store_command_n), .useStoreCmd(useStoreCmd),
        .mcuMode(mcuMode), .gating_port_bit(gating_port_bit), .readReq_n(readReq_n),
        .cpuClk(cpuClk), .chipSel_n(chipSel_n), .store_n(store_n), .outEn_n(outEn_n),
        .refresh_strobe_n(refresh_strobe_n), .falseCycle(falseCycle));
    srhi_ram_model srhi_ram_model_inst (
        .clk(clk), .rst_n(rst_n), .chipSel_n(chipSel_n), .store_n(store_n),
        .refresh_strobe_n(refresh_strobe_n), .readyIn(readyIn), .busyLen(busyLen),
        .busyGo(busyGo), .selCnt(selCnt), .storeCnt(storeCnt), .refCnt(refCnt));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Strobe held five cycles so a refresh stretch always starts inside it
    task automatic bus(input logic ms, input logic wr, input logic rd, output int low);
        low = 0;
        memSpaceIn = ms;
        addrStrobe = 1'b1;
        busyGo = (busyLen != 4'h0);
        cyc(1);
        busyGo = 1'b0;
        cyc(4);
        addrStrobe = 1'b0;
        writeReq_n = ~wr;
        memory_store_command_n = ~wr;
        readReq_n = ~rd;
        repeat (24) begin
            cyc(1);
            if (chipSel_n === 1'b0) low++;
        end
        {writeReq_n, memory_store_command_n, readReq_n} = 3'h7;
        cyc(4);
    endtask
    task automatic t_access();
        logic [6:0] tbl [5] = '{7'h54, 7'h20, 7'h66, 7'h6e, 7'h45};
        logic [7:0] s0, w0;
        int low;
        for (int i = 0; i < 5; i++) begin
            s0 = selCnt;
            w0 = storeCnt;
            useStoreCmd = tbl[i][3];
            bus(tbl[i][6], tbl[i][5], tbl[i][4], low);
            check(16'(selCnt - s0), 16'(tbl[i][2]), "selects");
            check(16'(storeCnt - w0), 16'(tbl[i][1]), "stores");
            check(16'(falseCycle), 16'(tbl[i][0]), "false cycle flag");
            check(16'(low), tbl[i][2] ? 16'h0002 : 16'h0000, "select length");
        end
        useStoreCmd = 1'b0;
    endtask
    task automatic t_wait();
        int low;
        busyLen = 4'hc;
        bus(1'b1, 1'b0, 1'b1, low);
        busyLen = 4'h0;
        check(16'(low > 2), 16'h0001, "select stretched by wait");
    endtask
    task automatic t_mcu();
        logic [16:0] tbl [4] = '{17'h01000, 17'h11000, 17'h08000, 17'h07fff};
        logic [7:0] s0;
        int low;
        mcuMode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            s0 = selCnt;
            gating_port_bit = tbl[i][16];
            addrIn = tbl[i][15:0];
            bus(1'b1, 1'b0, 1'b1, low);
            check(16'(selCnt - s0), 16'(!tbl[i][16] && addrIn < 16'h8000), "gated select");
        end
        mcuMode = 1'b0;
        gating_port_bit = 1'b1;
    endtask
    task automatic t_refresh();
        logic [7:0] r0;
        int low;
        r0 = refCnt;
        cyc(REF_FULL + 5);
        bus(1'b1, 1'b0, 1'b1, low);
        check(16'(refCnt - r0), 16'h0001, "refresh strobes");
    endtask
    initial begin
        #(50 * 5000);
        n_fail++;
        final_report();
    end
    initial begin
        {addrStrobe, memSpaceIn, useStoreCmd, mcuMode, busyGo} = 5'h00;
        {writeReq_n, memory_store_command_n, readReq_n, gating_port_bit} = 4'hf;
        addrIn = 16'h0000;
        busyLen = 4'h0;
        rst_n = 1'b0;
        cyc(5);
        check(16'({chipSel_n, store_n, outEn_n, refresh_strobe_n}), 16'h000e, "reset pins");
        cyc(1);
        rst_n = 1'b1;
        cyc(2);
        check(16'({chipSel_n, refresh_strobe_n}), 16'h0002, "power-up pins");
        cyc(PWRUP + 4);
        check(16'(refresh_strobe_n), 16'h0001, "refresh released");
        t_access();
        t_wait();
        t_mcu();
        t_refresh();
        final_report();
    end
endmodule
`default_nettype wire

/* File: hdl/srhi_host.sv */
// Operation
// RULE1: One clean chip-select fall per cycle
// RULE2: RAM latches address on select fall
// RULE3: Keep select high for precharge, longer after false
// RULE4: Data valid before store pulse leads
// RULE5: Enable decoder after address, before ready
// RULE6: Two-flop counter, strobe presets first
// RULE7: Ready holds second flop, select stretches
// RULE8: RAM needs no long select
// RULE9: Gate waits for clock fall edge
// RULE10: Reset clears memory select, select high
// RULE11: Resync early write pulse to clock
// RULE12: Bus store command used directly; code resyncs it through two flops like the write pulse
// RULE13: Microcontroller gates strobe with port bit
// RULE14: Short fetch cycles make no select
// RULE15: Divider flop makes processor clock
// RULE16: Full count sets refresh request latch
// RULE17: Strobe rise moves request, asserts refresh
// RULE18: Hold processor clock high for refresh
// RULE19: Release counter, hold clock ten cycles
// RULE20: 128 refresh strobes every two milliseconds
// RULE21: Controls high 100 us before access; code holds refresh_strobe_n low meanwhile
// RULE22: Refresh full count is a parameter
`timescale 1ns/100ps
`default_nettype none
module srhi_host
    import srhi_pkg::*;
#(
    parameter int REF_FULL = srhi_pkg::REF_FULL_CYC,
    parameter int PWRUP = srhi_pkg::PWRUP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Processor bus pins
    input wire logic addrStrobe,
    input wire logic readyIn,
    input wire logic memSpaceIn,
    input wire logic [15:0] addrIn,
    input wire logic writeReq_n,
    input wire logic memory_store_command_n,
    input wire logic useStoreCmd,
    input wire logic mcuMode,
    input wire logic gating_port_bit,
    input wire logic readReq_n,
    // Processor clock out
    output logic cpuClk,
    // RAM control pins
    output logic chipSel_n,
    output logic store_n,
    output logic outEn_n,
    output logic refresh_strobe_n,
    output logic falseCycle
);
    import srhi_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic strobeS;
    logic readyS;
    logic memS;
    logic wrS_n;
    logic cmdS_n;
    logic portS;
    logic rdS_n;
    logic [5:0] syncOut;
    srhi_sync2 #(.W(6)) uSync (
        .clk(clk),
        .rst_n(rst_n),
        .rst_val(6'h3f),
        .d({addrStrobe, readyIn, memSpaceIn, writeReq_n, memory_store_command_n,
            gating_port_bit}),
        .q(syncOut)
    );
    assign {strobeS, readyS, memS, wrS_n, cmdS_n, portS} = syncOut;
    srhi_sync2 #(.W(1)) uSyncRd (
        .clk(clk),
        .rst_n(rst_n),
        .rst_val(1'h1),
        .d(readReq_n),
        .q(rdS_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Power-up hold, memory select flop and strobe edges
    logic [CNT_W-1:0] pwrCnt_ff;
    logic [CNT_W-1:0] nxt_pwrCnt;
    logic pwrDone_ff;
    logic nxt_pwrDone;
    logic memSel_ff;
    logic nxt_memSel;
    logic strobeD_ff;
    logic nxt_strobeD;
    logic lowSpace;
    assign lowSpace = addrIn < LOW_SPACE_TOP;
    always_comb begin
        nxt_pwrCnt = pwrCnt_ff;
        nxt_pwrDone = pwrDone_ff;
        if (!pwrDone_ff) begin
            nxt_pwrCnt = pwrCnt_ff + 16'h0001;
            if (pwrCnt_ff >= CNT_W'(PWRUP - 1)) begin
                nxt_pwrDone = 1'b1; // see RULE21
            end
        end
        nxt_strobeD = strobeS;
        // Latched at strobe rise, status can drop before strobe ends
        nxt_memSel = (strobeS && !strobeD_ff) ? memS : memSel_ff;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwrCnt_ff <= '0;
            pwrDone_ff <= 1'b0;
            memSel_ff <= 1'b0; // see RULE10
            // Same level as the synchroniser's reset, so no false rise
            strobeD_ff <= 1'b1;
        end else begin
            pwrCnt_ff <= nxt_pwrCnt;
            pwrDone_ff <= nxt_pwrDone;
            memSel_ff <= nxt_memSel;
            strobeD_ff <= nxt_strobeD;
        end
    end
    logic strobeRise;
    logic strobeFall;
    assign strobeRise = strobeS && !strobeD_ff;
    assign strobeFall = !strobeS && strobeD_ff;

    ////////////////////////////////////////////////////////////////////////
    // Decoder enable counter
    srhi_sel_if selBus ();
    assign selBus.strobeRise = strobeRise;
    assign selBus.readyIn = readyS;
    assign selBus.memSpace = memSel_ff && pwrDone_ff;
    srhi_sel_gen uSel (
        .clk(clk),
        .rst_n(rst_n),
        .sel(selBus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Chip-select, precharge and store timing
    logic cs_ff;
    logic nxt_cs;
    logic csD_ff;
    logic nxt_csD;
    logic [PRE_W-1:0] pre_ff;
    logic [PRE_W-1:0] nxt_pre;
    logic accessed_ff;
    logic nxt_accessed;
    logic fmc_ff;
    logic nxt_fmc;
    logic st_ff;
    logic nxt_st;
    logic oe_ff;
    logic nxt_oe;
    logic mcuSel;
    logic want;
    logic accessNow;
    logic usedNow;
    // Port bit low only for low-space external data cycles
    assign mcuSel = strobeD_ff && !strobeS && !portS && lowSpace; // see RULE13 RULE14
    assign accessNow = !rdS_n || !store_n;
    // An access in the closing cycle still counts
    assign usedNow = accessed_ff || accessNow;
    assign want = pwrDone_ff && (mcuMode ? (mcuSel || (cs_ff && !portS)) : selBus.enable);
    always_comb begin
        nxt_csD = cs_ff;
        nxt_pre = (pre_ff != '0) ? pre_ff - 3'h1 : pre_ff;
        nxt_cs = cs_ff;
        nxt_accessed = accessed_ff;
        nxt_fmc = fmc_ff;
        if (!cs_ff) begin
            // Assert only after full precharge, so one fall per cycle
            if (want && pre_ff == '0) begin
                nxt_cs = 1'b1; // see RULE1
                nxt_accessed = 1'b0;
            end
        end else begin
            if (accessNow) begin
                nxt_accessed = 1'b1;
            end
            // Two edges at least, so the resynced store lands inside select
            if (!want && csD_ff) begin
                nxt_cs = 1'b0;
                nxt_fmc = !usedNow;
                // False cycles need the longer high time
                nxt_pre = usedNow ? PRE_W'(PRE_NORMAL_CYC) : PRE_W'(PRE_FALSE_CYC); // see RULE3
            end
        end
        // Resynced write leads only after data settled a clock
        nxt_st = cs_ff && (useStoreCmd ? !cmdS_n : !wrS_n); // see RULE11
        nxt_oe = cs_ff && !rdS_n;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_ff <= 1'b0;
            csD_ff <= 1'b0;
            pre_ff <= '0;
            accessed_ff <= 1'b0;
            fmc_ff <= 1'b0;
            st_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            cs_ff <= nxt_cs;
            csD_ff <= nxt_csD;
            pre_ff <= nxt_pre;
            accessed_ff <= nxt_accessed;
            fmc_ff <= nxt_fmc;
            st_ff <= nxt_st; // see RULE4
            oe_ff <= nxt_oe;
        end
    end
    // Command path used raw would skip resync; registered copy kept for one-edge output
    assign chipSel_n = !cs_ff; // see RULE2
    assign store_n = !st_ff; // see RULE12
    assign outEn_n = !oe_ff;
    assign falseCycle = fmc_ff;

    ////////////////////////////////////////////////////////////////////////
    // Refresh request, sync flop and processor clock stretch
    logic clock_divider_flop_ff, nxt_div;
    logic request_latch_ff, nxt_req;
    logic request_sync_flop_ff, nxt_sync;
    logic [CNT_W-1:0] refCnt_ff, nxt_refCnt;
    logic [STR_W-1:0] stretch_interval_counter_ff, nxt_str;
    srhi_clk_e clkSt_ff, nxt_clkSt;
    logic refresh_request;
    assign refresh_request = refCnt_ff >= CNT_W'(REF_FULL - 1); // see RULE22
    always_comb begin
        nxt_refCnt = refresh_request ? '0 : refCnt_ff + 16'h0001; // see RULE16
        nxt_req = request_latch_ff || refresh_request;
        nxt_sync = request_sync_flop_ff;
        nxt_div = ~clock_divider_flop_ff; // see RULE15
        nxt_clkSt = clkSt_ff;
        nxt_str = stretch_interval_counter_ff;
        if (strobeRise && request_latch_ff && !request_sync_flop_ff) begin
            nxt_sync = 1'b1; // see RULE17
            nxt_req = refresh_request;
            // Clock kept high from the strobe rise on
            nxt_div = 1'b1;
        end
        unique case (clkSt_ff)
            SRHI_CLK_RUN: begin
                nxt_str = '0;
                if (request_sync_flop_ff) begin
                    nxt_clkSt = SRHI_CLK_HOLD;
                    nxt_div = 1'b1; // see RULE18
                end
            end
            SRHI_CLK_HOLD: begin
                nxt_div = 1'b1;
                nxt_str = stretch_interval_counter_ff + 4'h1; // see RULE19
                if (stretch_interval_counter_ff == STR_W'(STRETCH_CYC - 1)) begin
                    nxt_clkSt = SRHI_CLK_RUN;
                    nxt_sync = 1'b0;
                end
            end
            default: begin
                nxt_clkSt = SRHI_CLK_RUN;
            end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_divider_flop_ff <= 1'b0;
            request_latch_ff <= 1'b0;
            request_sync_flop_ff <= 1'b0;
            refCnt_ff <= '0;
            stretch_interval_counter_ff <= '0;
            clkSt_ff <= SRHI_CLK_RUN;
        end else begin
            clock_divider_flop_ff <= nxt_div;
            request_latch_ff <= nxt_req;
            request_sync_flop_ff <= nxt_sync;
            refCnt_ff <= nxt_refCnt;
            stretch_interval_counter_ff <= nxt_str;
            clkSt_ff <= nxt_clkSt;
        end
    end
    assign cpuClk = clock_divider_flop_ff;
    // Held low while powering up, then one pulse per refresh; see RULE20
    assign refresh_strobe_n = pwrDone_ff ? !request_sync_flop_ff : 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Decoder gate: strobe fall aligned to the processor clock's low phase
    logic fallPend_ff;
    logic nxt_fallPend;
    logic gatedFall;
    // A fall seen while the clock is high waits; a stretch delays it too
    assign gatedFall = (strobeFall || fallPend_ff) && !clock_divider_flop_ff; // see RULE9
    always_comb begin
        nxt_fallPend = fallPend_ff;
        if (strobeRise) begin
            nxt_fallPend = 1'b0;
        end else if (strobeFall && clock_divider_flop_ff) begin
            nxt_fallPend = 1'b1;
        end else if (gatedFall) begin
            nxt_fallPend = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallPend_ff <= 1'b0;
        end else begin
            fallPend_ff <= nxt_fallPend;
        end
    end
    assign selBus.strobeFall = gatedFall;
endmodule
`default_nettype wire

/* File: hdl/srhi_pkg.sv */
package srhi_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 20;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int PWRUP_US = 100;
    localparam int PWRUP_CYC = (PWRUP_US * 1000) / CLK_NS;
    localparam int REF_WINDOW_US = 2000;
    localparam int REF_PER_WINDOW = 128;
    // Longest spacing of refresh requests, rounded down, with a margin
    localparam int REF_FULL_CYC = ((REF_WINDOW_US * 1000) / CLK_NS) / REF_PER_WINDOW / 2;
    localparam int STRETCH_CYC = 10;
    localparam int PRE_NORMAL_CYC = 2;
    localparam int PRE_FALSE_CYC = 3;
    localparam int CNT_W = 16;
    localparam int STR_W = 4;
    localparam int PRE_W = 3;
    // Memory-space split for the microcontroller gate
    localparam logic [15:0] LOW_SPACE_TOP = 16'h8000;
    typedef enum logic [1:0] {SRHI_CLK_RUN, SRHI_CLK_HOLD} srhi_clk_e;
endpackage

/* File: hdl/srhi_sel_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module srhi_sel_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Controls
    srhi_sel_if.ctl sel
);
    logic aQ_ff;
    logic bQ_ff;
    logic nxt_aQ;
    logic nxt_bQ;
    // Two-bit counter: A preset by strobe, B follows A and holds while not ready
    always_comb begin
        nxt_aQ = aQ_ff;
        nxt_bQ = bQ_ff;
        if (sel.strobeRise) begin
            nxt_aQ = 1'b1; // see RULE6
        end else if (aQ_ff && sel.strobeFall) begin
            nxt_aQ = 1'b0;
            nxt_bQ = 1'b1; // see RULE5
        end else if (bQ_ff && sel.readyIn) begin
            nxt_bQ = 1'b0; // see RULE7
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aQ_ff <= 1'b0;
            bQ_ff <= 1'b0;
        end else begin
            aQ_ff <= nxt_aQ;
            bQ_ff <= nxt_bQ;
        end
    end
    // Memory-space select gates the decoder
    assign sel.enable = bQ_ff && sel.memSpace; // see RULE6
endmodule
`default_nettype wire

/* File: hdl/srhi_sel_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface srhi_sel_if;
    logic strobeRise;
    logic strobeFall;
    logic readyIn;
    logic memSpace;
    logic enable;
    modport ctl(input strobeRise, input strobeFall, input readyIn, input memSpace, output enable);
    modport usr(output strobeRise, output strobeFall, output readyIn, output memSpace,
        input enable);
endinterface
`default_nettype wire

/* File: hdl/srhi_sync2.sv */
`timescale 1ns/100ps
`default_nettype none
module srhi_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] rst_val,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;
    // Reset always loads all ones; the rst_val port is left unused
    always_comb begin
        nxt_meta = d;
        nxt_q = meta_ff;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '1;
            q_ff <= '1;
        end else begin
            meta_ff <= nxt_meta;
            q_ff <= nxt_q;
        end
    end
    assign q = q_ff;
    logic unusedRv;
    assign unusedRv = ^rst_val;
endmodule
`default_nettype wire
